// >>> inc/zst_defs.svh
// register offsets, reset values and function codes of the zero-servo block
// assumes a 32-bit apb with byte addresses, one aligned word per register
`ifndef ZST_DEFS_SVH
`define ZST_DEFS_SVH
`define ZST_OFF_GAIN 8'h00
`define ZST_OFF_CNT 8'h04
`define ZST_OFF_MODE 8'h08
`define ZST_OFF_MFSEL 8'h0C
`define ZST_OFF_CFSEL 8'h10
`define ZST_OFF_MLVL 8'h14
`define ZST_OFF_CLVL 8'h18
`define ZST_OFF_ZSPD 8'h1C
`define ZST_OFF_DIN_LO 8'h20
`define ZST_OFF_DIN_HI 8'h24
`define ZST_OFF_DOUT 8'h28
`define ZST_OFF_STAT 8'h2C
`define ZST_OFF_POS 8'h30
`define ZST_OFF_IRQ 8'h34
`define ZST_OFF_MASK 8'h38
`define ZST_RST_GAIN 7'h05
`define ZST_MAX_GAIN 7'h64
`define ZST_RST_CNT 14'h000A
`define ZST_RST_FSEL 5'h1F
`define ZST_RST_MLVL 1'h0
`define ZST_RST_CLVL 2'h2
`define ZST_RST_ZSPD 16'h0010
`define ZST_FN_LOCK 8'h48
`define ZST_FN_DONE 8'h21
`define ZST_FN_TORQ 5'h13
`define ZST_LVL_BIPOLAR 2'h1
`define ZST_LVL_CURRENT 2'h2
`endif

// >>> inc/zst_pkg.sv
// types shared by the zero-servo and torque-select block
// assumes zst_defs.svh for all numeric constants
package zst_pkg;
  typedef enum logic [1:0] {
    ZST_IDLE = 2'b01,
    ZST_LOCK = 2'b10
  } zst_state_e;
  // configuration that is frozen while the motor runs
  typedef struct packed {
    logic [6:0] gain;
    logic [13:0] cnt;
    logic flux;
    logic torq;
    logic [4:0] mfsel;
    logic [4:0] cfsel;
    logic mlvl;
    logic [1:0] clvl;
  } zst_cfg_s;
  // interrupt events: lock entered, lock complete, lock left
  typedef struct packed {
    logic left;
    logic done;
    logic enter;
  } zst_evt_s;
endpackage : zst_pkg

// >>> hdl/zst_top.sv
// zero-servo position lock and speed/torque control select with apb regs
// assumes encoder and terminal inputs already synchronous to CLK
//
// The APB interface to the registers and the address map were left to the implementer.
`include "zst_defs.svh"
module zst_top
  import zst_pkg::*;
#(
  parameter int DW = 16,
  parameter int PW = 32
)(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RUN,
  input wire logic [5:0] DIN,
  input wire logic ENC_A,
  input wire logic ENC_B,
  input wire logic signed [DW-1:0] SPEED_REF,
  input wire logic signed [DW-1:0] MAI_VAL,
  input wire logic signed [DW-1:0] CUR_VAL,
  output logic [2:0] DOUT,
  output logic LOCK_ACTIVE,
  output logic signed [DW-1:0] SPEED_CMD,
  output logic signed [DW-1:0] TORQUE_REF,
  output logic TORQUE_MODE,
  output logic TORQUE_REV,
  output logic IRQ
);
  localparam logic signed [DW-1:0] SMAX = {1'b0, {(DW-1){1'b1}}};
  localparam logic signed [DW-1:0] SMIN = {1'b1, {(DW-1){1'b0}}};

  // magnitude of a signed word
  function automatic logic [DW-1:0] mag(input logic signed [DW-1:0] v);
    mag = v[DW-1] ? DW'(-v) : DW'(v);
  endfunction : mag

  // saturate a wide signed value to the output width
  function automatic logic signed [DW-1:0] sat(
    input logic signed [PW+7:0] v);
    if (v > PW'(SMAX) + 40'sh0)
      sat = SMAX;
    else if (v < $signed({{(PW+8-DW){1'b1}}, SMIN}))
      sat = SMIN;
    else
      sat = v[DW-1:0];
  endfunction : sat

  zst_cfg_s cfg_r;
  zst_state_e state_r;
  zst_evt_s evt;
  logic [DW-1:0] zspd_r;
  logic [47:0] din_fsel_r;
  logic [23:0] dout_fsel_r;
  logic [2:0] irq_r, mask_r;
  logic a_r, b_r, done_r;
  logic signed [PW-1:0] pos_r, start_r;
  logic [5:0] din_hit;
  logic [2:0] dout_hit;
  logic lock_en, lock_cmd, done_any, enter, leave, done_nxt;
  logic signed [PW-1:0] dev;
  logic [PW-1:0] dev_mag;
  logic setup, access, wr, rd, frozen, bad;
  logic [31:0] rdata;

  // function decode of digital inputs and outputs
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_din
      assign din_hit[gi] = din_fsel_r[gi*8 +: 8] == `ZST_FN_LOCK;
    end
    for (gi = 0; gi < 3; gi++)
    begin : g_dout
      assign dout_hit[gi] = dout_fsel_r[gi*8 +: 8] == `ZST_FN_DONE;
    end
  endgenerate

  // lock command and entry/exit conditions
  assign lock_en = |din_hit;
  assign lock_cmd = |(din_hit & DIN);
  assign done_any = |dout_hit;
  assign enter = state_r == ZST_IDLE && lock_cmd && RUN
    && mag(SPEED_REF) < zspd_r;
  assign leave = state_r == ZST_LOCK && (!lock_cmd || !RUN);
  assign dev = pos_r - start_r;
  assign dev_mag = dev[PW-1] ? PW'(-dev) : PW'(dev);
  assign done_nxt = state_r == ZST_LOCK && !leave && done_any
    && dev_mag <= PW'(cfg_r.cnt);

  // lock state machine
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      state_r <= ZST_IDLE;
    else
      case (state_r)
        ZST_IDLE: if (enter) state_r <= ZST_LOCK;
        ZST_LOCK: if (leave) state_r <= ZST_IDLE;
        default: state_r <= ZST_IDLE;
      endcase
  end

  // quadrature counter, every edge of both phases
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      a_r <= 1'b0;
      b_r <= 1'b0;
      pos_r <= '0;
    end
    else
    begin
      a_r <= ENC_A;
      b_r <= ENC_B;
      if ((ENC_A ^ a_r) ^ (ENC_B ^ b_r))
        pos_r <= (a_r ^ ENC_B) ? pos_r + 1'b1 : pos_r - 1'b1;
    end
  end

  // start position captured at lock entry
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      start_r <= '0;
    else if (enter)
      start_r <= pos_r;
  end

  // lock outputs; the position loop overrides any reference offset
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      LOCK_ACTIVE <= 1'b0;
      SPEED_CMD <= '0;
      done_r <= 1'b0;
      DOUT <= 3'h0;
    end
    else
    begin
      LOCK_ACTIVE <= enter || (state_r == ZST_LOCK && !leave);
      if (enter)
        SPEED_CMD <= '0; // deviation is zero at the captured start
      else if (state_r == ZST_LOCK && !leave)
        SPEED_CMD <= sat(-($signed({{8{dev[PW-1]}}, dev})
          * $signed({1'b0, cfg_r.gain})));
      else
        SPEED_CMD <= SPEED_REF;
      done_r <= done_nxt;
      DOUT <= dout_hit & {3{done_r}};
    end
  end

  // torque reference source, level and direction
  logic signed [DW-1:0] tsrc;
  logic tvalid, tbip;
  always_comb
  begin
    tsrc = '0;
    tvalid = 1'b0;
    tbip = 1'b0;
    if (cfg_r.mfsel == `ZST_FN_TORQ)
    begin
      tsrc = MAI_VAL;
      tvalid = 1'b1;
      tbip = {1'b0, cfg_r.mlvl} == `ZST_LVL_BIPOLAR;
    end
    else if (cfg_r.cfsel == `ZST_FN_TORQ)
    begin
      tsrc = CUR_VAL;
      tvalid = 1'b1;
      tbip = cfg_r.clvl == `ZST_LVL_BIPOLAR;
    end
  end

  // torque outputs; no panel entry path exists for the value
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      TORQUE_MODE <= 1'b0;
      TORQUE_REF <= '0;
      TORQUE_REV <= 1'b0;
    end
    else
    begin
      TORQUE_MODE <= cfg_r.flux && cfg_r.torq && tvalid;
      if (tsrc[DW-1] && !tbip)
        TORQUE_REF <= '0;
      else
        TORQUE_REF <= tsrc;
      TORQUE_REV <= tsrc[DW-1] && tbip;
    end
  end

  // apb decode: no wait state, answer in the first access cycle
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE && PREADY;
  assign wr = access && PWRITE && !PSLVERR;
  assign rd = access && !PWRITE;
  assign frozen = PADDR <= `ZST_OFF_CLVL; // settings locked while running
  always_comb
  begin
    bad = 1'b0;
    rdata = 32'h0;
    case (PADDR)
      `ZST_OFF_GAIN: rdata = {25'h0, cfg_r.gain};
      `ZST_OFF_CNT: rdata = {18'h0, cfg_r.cnt};
      `ZST_OFF_MODE: rdata = {30'h0, cfg_r.flux, cfg_r.torq};
      `ZST_OFF_MFSEL: rdata = {27'h0, cfg_r.mfsel};
      `ZST_OFF_CFSEL: rdata = {27'h0, cfg_r.cfsel};
      `ZST_OFF_MLVL: rdata = {31'h0, cfg_r.mlvl};
      `ZST_OFF_CLVL: rdata = {30'h0, cfg_r.clvl};
      `ZST_OFF_ZSPD: rdata = 32'(zspd_r);
      `ZST_OFF_DIN_LO: rdata = din_fsel_r[31:0];
      `ZST_OFF_DIN_HI: rdata = {16'h0, din_fsel_r[47:32]};
      `ZST_OFF_DOUT: rdata = {8'h0, dout_fsel_r};
      `ZST_OFF_STAT: rdata = {27'h0, RUN, lock_en, TORQUE_MODE, done_r,
        state_r == ZST_LOCK};
      `ZST_OFF_POS: rdata = 32'(dev);
      `ZST_OFF_IRQ: rdata = {29'h0, irq_r};
      `ZST_OFF_MASK: rdata = {29'h0, mask_r};
      default: bad = 1'b1;
    endcase
    if (PWRITE && RUN && frozen)
      bad = 1'b1;
    if (PWRITE && PADDR == `ZST_OFF_GAIN && PWDATA[6:0] > `ZST_MAX_GAIN)
      bad = 1'b1;
    if (PWRITE && PADDR == `ZST_OFF_MLVL && PWDATA[1])
      bad = 1'b1;
    if (PWRITE && PADDR == `ZST_OFF_CLVL && PWDATA[1:0] == 2'h3)
      bad = 1'b1;
    if (PWRITE && (PADDR == `ZST_OFF_STAT || PADDR == `ZST_OFF_POS
      || PADDR == `ZST_OFF_IRQ))
      bad = 1'b1;
  end

  // apb answer registers
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
    end
    else
    begin
      PREADY <= setup;
      PSLVERR <= setup && bad;
      PRDATA <= (setup && !PWRITE) ? rdata : 32'h0;
    end
  end

  // writable configuration
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cfg_r <= '{gain: `ZST_RST_GAIN, cnt: `ZST_RST_CNT, flux: 1'b0,
        torq: 1'b0, mfsel: `ZST_RST_FSEL, cfsel: `ZST_RST_FSEL,
        mlvl: `ZST_RST_MLVL, clvl: `ZST_RST_CLVL};
      zspd_r <= `ZST_RST_ZSPD;
      din_fsel_r <= 48'h0;
      dout_fsel_r <= 24'h0;
      mask_r <= 3'h0;
    end
    else if (wr)
      case (PADDR)
        `ZST_OFF_GAIN: cfg_r.gain <= PWDATA[6:0];
        `ZST_OFF_CNT: cfg_r.cnt <= PWDATA[13:0];
        `ZST_OFF_MODE: {cfg_r.flux, cfg_r.torq} <= PWDATA[1:0];
        `ZST_OFF_MFSEL: cfg_r.mfsel <= PWDATA[4:0];
        `ZST_OFF_CFSEL: cfg_r.cfsel <= PWDATA[4:0];
        `ZST_OFF_MLVL: cfg_r.mlvl <= PWDATA[0];
        `ZST_OFF_CLVL: cfg_r.clvl <= PWDATA[1:0];
        `ZST_OFF_ZSPD: zspd_r <= PWDATA[DW-1:0];
        `ZST_OFF_DIN_LO: din_fsel_r[31:0] <= PWDATA;
        `ZST_OFF_DIN_HI: din_fsel_r[47:32] <= PWDATA[15:0];
        `ZST_OFF_DOUT: dout_fsel_r <= PWDATA[23:0];
        `ZST_OFF_MASK: mask_r <= PWDATA[2:0];
        default: mask_r <= mask_r;
      endcase
  end

  // sticky events, cleared by a read; a new event wins over the clear
  assign evt = '{left: leave, done: done_nxt && !done_r, enter: enter};
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      irq_r <= 3'h0;
      IRQ <= 1'b0;
    end
    else
    begin
      irq_r <= (rd && PADDR == `ZST_OFF_IRQ ? 3'h0 : irq_r) | evt;
      IRQ <= |(((rd && PADDR == `ZST_OFF_IRQ ? 3'h0 : irq_r) | evt)
        & mask_r);
    end
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  AST_ENTER: assert property (
    enter |=> LOCK_ACTIVE && state_r == ZST_LOCK)
    else $error("lock not entered");
  AST_NO_CFG: assert property (
    !lock_en |=> !LOCK_ACTIVE)
    else $error("lock active without function 72 input");
  AST_RUN_OFF: assert property (
    !RUN |=> !LOCK_ACTIVE ##1 !done_r)
    else $error("lock survives run off");
  AST_CMD_OFF: assert property (
    !lock_cmd |=> !done_r ##1 DOUT == 3'h0)
    else $error("complete not dropped");
  AST_NO33: assert property (
    !done_any |=> !done_r)
    else $error("complete without function 33 output");
  AST_RANGE: assert property (
    done_r |-> $past(dev_mag) <= PW'($past(cfg_r.cnt)))
    else $error("complete outside window");
  AST_DOUT: assert property (
    done_r && dout_hit[0] |=> DOUT[0])
    else $error("output 0 missing complete");
  AST_FROZEN: assert property (
    access && PWRITE && RUN && PADDR == `ZST_OFF_GAIN |=> $stable(cfg_r))
    else $error("setting changed while running");
  AST_FWD_STEP: assert property (
    !a_r && !b_r && !ENC_A && ENC_B |=> pos_r == $past(pos_r) + 1)
    else $error("encoder edge not counted");
  AST_UNIPOLAR: assert property (
    TORQUE_REV |-> $past(tbip) && TORQUE_REF < 0)
    else $error("reverse torque without bipolar level");
  AST_TMODE: assert property (
    TORQUE_MODE |-> $past(cfg_r.flux && cfg_r.torq))
    else $error("torque mode outside flux vector");
  AST_HOLD: assert property (
    LOCK_ACTIVE && $past(dev) == 0 |-> SPEED_CMD == 0)
    else $error("speed offset leaks through lock");

  CVR_LOCK: cover property (enter ##[1:50] done_r);
  CVR_REFUSE: cover property (access && PSLVERR && RUN);
  CVR_TORQ: cover property (TORQUE_MODE && TORQUE_REV);
  CVR_IRQ: cover property (IRQ ##1 rd && PADDR == `ZST_OFF_IRQ);
endmodule : zst_top

// >>> sim/zst_enc_model.sv
// quadrature encoder stand-in for the motor shaft
// assumes one step pulse per count from the bench, levels on clk
module zst_enc_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic step,
  input wire logic dir,
  output logic enc_a,
  output logic enc_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_r;
  // gray walk 00,01,11,10 forward: one phase moves per step
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ph_r <= 2'h0;
    else if (step)
      ph_r <= dir ? ph_r + 2'h1 : ph_r - 2'h1;
  end
  // phases from the gray code, edges on both a and b
  assign enc_a = ph_r[1];
  assign enc_b = ph_r[1] ^ ph_r[0];
endmodule : zst_enc_model

// >>> sim/zst_top_bench.sv
// self-checking bench: apb register access, position lock, torque select
// assumes zst_enc_model on the encoder pins, apb answer in one cycle
`include "zst_defs.svh"
module zst_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, run, step, dir;
  logic enc_a, enc_b, tmode, trev, lock, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0] din;
  logic [2:0] dout;
  logic signed [15:0] spd, mai, cur, scmd, tref;
  int error_cnt, n_checks, cyc;
  zst_top u_zst_top (.CLK(clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RUN(run),
    .DIN(din), .ENC_A(enc_a), .ENC_B(enc_b), .SPEED_REF(spd),
    .MAI_VAL(mai), .CUR_VAL(cur), .DOUT(dout), .LOCK_ACTIVE(lock),
    .SPEED_CMD(scmd), .TORQUE_REF(tref), .TORQUE_MODE(tmode),
    .TORQUE_REV(trev), .IRQ(irq));
  zst_enc_model u_zst_enc_model (.clk(clk), .nrst(nrst), .step(step),
    .dir(dir), .enc_a(enc_a), .enc_b(enc_b));
  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      error_cnt++;
      $display("ERROR at %0t: run timed out", $time);
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, judged on data (reads) and error flag
  task automatic acc(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [31:0] exp, input logic e);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      error_cnt++;
      $display("ERROR at %0t: no pready", $time);
    end
    if (!w)
      chk(prdata, exp);
    chk(pslverr, e);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : acc
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle
  task automatic enc(input int n, input logic d);
    repeat (n)
    begin
      @(posedge clk);
      step <= 1'b1;
      dir <= d;
      @(posedge clk);
      step <= 1'b0;
      @(posedge clk);
    end
  endtask : enc
  task automatic t_regs;
    acc(1'b0, `ZST_OFF_GAIN, 32'h0, 32'h5, 1'b0);
    acc(1'b0, `ZST_OFF_CNT, 32'h0, 32'hA, 1'b0);
    acc(1'b0, `ZST_OFF_MODE, 32'h0, 32'h0, 1'b0);
    acc(1'b0, `ZST_OFF_MFSEL, 32'h0, 32'h1F, 1'b0);
    acc(1'b0, `ZST_OFF_CFSEL, 32'h0, 32'h1F, 1'b0);
    acc(1'b0, `ZST_OFF_MLVL, 32'h0, 32'h0, 1'b0);
    acc(1'b0, `ZST_OFF_CLVL, 32'h0, 32'h2, 1'b0);
    acc(1'b0, 8'h3C, 32'h0, 32'h0, 1'b1);
    acc(1'b1, `ZST_OFF_GAIN, 32'h65, 32'h0, 1'b1);
    acc(1'b0, `ZST_OFF_GAIN, 32'h0, 32'h5, 1'b0);
    acc(1'b1, `ZST_OFF_GAIN, 32'h64, 32'h0, 1'b0);
    acc(1'b0, `ZST_OFF_GAIN, 32'h0, 32'h64, 1'b0);
    acc(1'b1, `ZST_OFF_GAIN, 32'h5, 32'h0, 1'b0);
    acc(1'b1, `ZST_OFF_CLVL, 32'h3, 32'h0, 1'b1);
    acc(1'b1, `ZST_OFF_MLVL, 32'h2, 32'h0, 1'b1);
    acc(1'b1, `ZST_OFF_STAT, 32'h0, 32'h0, 1'b1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_lock;
    @(posedge clk);
    din <= 6'h01;
    run <= 1'b1;
    spd <= 16'sh0005;
    settle(4);
    chk(lock, 32'h0);
    chk(scmd, 32'h5);
    @(posedge clk);
    run <= 1'b0;
    acc(1'b1, `ZST_OFF_DIN_LO, 32'h48, 32'h0, 1'b0);
    acc(1'b1, `ZST_OFF_DOUT, 32'h21, 32'h0, 1'b0);
    acc(1'b1, `ZST_OFF_CNT, 32'h4, 32'h0, 1'b0);
    acc(1'b1, `ZST_OFF_MASK, 32'h1, 32'h0, 1'b0);
    @(posedge clk);
    run <= 1'b1;
    spd <= 16'sh0010;
    settle(4);
    chk(lock, 32'h0);
    @(posedge clk);
    spd <= 16'sh0005;
    settle(4);
    chk(lock, 32'h1);
    chk(scmd, 32'h0);
    chk(dout, 32'h1);
    chk(irq, 32'h1);
    acc(1'b1, `ZST_OFF_GAIN, 32'h7, 32'h0, 1'b1);
    enc(4, 1'b1);
    settle(3);
    chk(dout[0], 32'h1);
    acc(1'b0, `ZST_OFF_POS, 32'h0, 32'h4, 1'b0);
    enc(1, 1'b1);
    settle(3);
    chk(dout[0], 32'h0);
    chk(scmd, 32'hFFFFFFE7);
    enc(5, 1'b0);
    settle(3);
    chk(dout[0], 32'h1);
    acc(1'b0, `ZST_OFF_IRQ, 32'h0, 32'h3, 1'b0);
    settle(2);
    chk(irq, 32'h0);
    acc(1'b0, `ZST_OFF_IRQ, 32'h0, 32'h0, 1'b0);
    @(posedge clk);
    din <= 6'h00;
    settle(3);
    chk(dout[0], 32'h0);
    chk(lock, 32'h0);
    @(posedge clk);
    din <= 6'h01;
    settle(3);
    chk(lock, 32'h1);
    @(posedge clk);
    run <= 1'b0;
    settle(3);
    chk(lock, 32'h0);
    @(posedge clk);
    din <= 6'h00;
    $display("test lock done");
  endtask : t_lock
  task automatic t_torque;
    acc(1'b1, `ZST_OFF_MODE, 32'h3, 32'h0, 1'b0);
    acc(1'b1, `ZST_OFF_MFSEL, 32'h13, 32'h0, 1'b0);
    @(posedge clk);
    mai <= 16'shFF9C;
    settle(4);
    chk(tmode, 32'h1);
    chk(tref, 32'h0);
    chk(trev, 32'h0);
    acc(1'b1, `ZST_OFF_MLVL, 32'h1, 32'h0, 1'b0);
    settle(4);
    chk(tref, 32'hFFFFFF9C);
    chk(trev, 32'h1);
    acc(1'b1, `ZST_OFF_MODE, 32'h1, 32'h0, 1'b0);
    settle(4);
    chk(tmode, 32'h0);
    acc(1'b1, `ZST_OFF_MODE, 32'h2, 32'h0, 1'b0);
    settle(4);
    chk(tmode, 32'h0);
    acc(1'b1, `ZST_OFF_MODE, 32'h3, 32'h0, 1'b0);
    acc(1'b1, `ZST_OFF_MFSEL, 32'h1F, 32'h0, 1'b0);
    acc(1'b1, `ZST_OFF_CFSEL, 32'h13, 32'h0, 1'b0);
    @(posedge clk);
    cur <= 16'sh00C8;
    settle(4);
    chk(tmode, 32'h1);
    chk(tref, 32'hC8);
    @(posedge clk);
    cur <= 16'shFFCE;
    settle(4);
    chk(tref, 32'h0);
    $display("test torque done");
  endtask : t_torque
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // reset, then the scenarios in turn
  initial
  begin
    {nrst, psel, penable, pwrite, run, step, dir} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    din = 6'h00;
    spd = 16'sh0000;
    mai = 16'sh0000;
    cur = 16'sh0000;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_lock();
    t_torque();
    complete_run();
  end
endmodule : zst_top_bench
